// [logic/sfr_decode_pkg.sv]
package sfr_decode_pkg;
    // Register space and page values
    localparam logic [7:0] PAGE_SEL_ADDR = 8'hA7;
    localparam logic [7:0] PAGE_RESET = 8'h00;
    localparam logic [7:0] PAGE_ZERO = 8'h00;
    localparam logic [7:0] PAGE_F = 8'h0F;
    // Bit-addressable RAM bytes start here
    localparam logic [7:0] BIT_RAM_BASE = 8'h20;
    localparam logic [7:0] FULL_BYTE_MASK = 8'hFF;
    localparam logic [7:0] ONE_BIT = 8'h01;
    // Occupancy per page, bit n stands for address 0x80 + n
    localparam logic [127:0] PAGE0_OCC_MASK = 128'hFFFF_FFFF_FFFF_FFFF_FFEF_FFFF_FFFF_FFFF;
    localparam logic [127:0] PAGEF_OCC_MASK = 128'h00C9_00ED_4001_0000_1A20_0381_7E01_60FF;
    localparam logic [127:0] SHARED_MASK = 128'h00C1_00E1_0001_0000_1B80_0381_5401_80FF;

    // Source of a pending read answer
    typedef enum logic [4:0] {
        RD_NONE = 5'b00001,
        RD_SFR = 5'b00010,
        RD_RAM = 5'b00100,
        RD_PAGE = 5'b01000,
        RD_ZERO = 5'b10000
    } read_src_t;
endpackage : sfr_decode_pkg

// [logic/sfr_page_map.sv]
`timescale 1ns/1ps
module sfr_page_map (
    input wire logic [7:0] addr_in,   // Byte address in register space
    input wire logic [7:0] page_in,   // Active page
    output logic occupied_out,        // Address holds a register on this page
    output logic shared_out           // Register answers on every page
);
    logic [6:0] idx;

    // Table lookup against the page maps
    always_comb begin
        idx = addr_in[6:0];
        shared_out = sfr_decode_pkg::SHARED_MASK[idx];
        occupied_out = sfr_decode_pkg::SHARED_MASK[idx]
            | ((page_in == sfr_decode_pkg::PAGE_ZERO) & sfr_decode_pkg::PAGE0_OCC_MASK[idx])
            | ((page_in == sfr_decode_pkg::PAGE_F) & sfr_decode_pkg::PAGEF_OCC_MASK[idx]);
    end
endmodule : sfr_page_map

// [logic/sfr_space_page_decoder.sv]
`timescale 1ns/1ps
module sfr_space_page_decoder (
    input wire logic sys_clk_in,          // Core clock
    input wire logic rst_n_in,            // Async reset, active low
    input wire logic acc_valid_in,        // Access request, one cycle
    input wire logic acc_direct_in,       // 1 direct addressing, 0 indirect
    input wire logic acc_bit_in,          // Bit access, address is a bit address
    input wire logic acc_write_in,        // 1 write, 0 read
    input wire logic [7:0] acc_addr_in,   // Byte or bit address
    input wire logic [7:0] acc_wdata_in,  // Write data, bit 0 for bit writes
    input wire logic [7:0] sfr_rdata_in,  // Peripheral read data during sfr_rd_out
    input wire logic [7:0] ram_rdata_in,  // RAM read data during ram_rd_out
    output logic sfr_rd_out,              // Register read strobe
    output logic sfr_wr_out,              // Register write strobe
    output logic [7:0] sfr_addr_out,      // Register byte address
    output logic [7:0] sfr_page_out,      // Page for this access
    output logic sfr_shared_out,          // Target answers on all pages
    output logic ram_rd_out,              // Internal RAM read strobe
    output logic ram_wr_out,              // Internal RAM write strobe
    output logic [7:0] ram_addr_out,      // Internal RAM byte address
    output logic [7:0] bit_mask_out,      // Byte lanes written, one bit for bit writes
    output logic [7:0] wdata_out,         // Write data
    output logic reserved_out,            // Reserved address touched, pulse
    output logic rd_valid_out,            // Read answer valid, pulse
    output logic [7:0] rd_data_out,       // Read answer
    output logic [7:0] page_out           // Current page select value
);
    logic [7:0] register_page_select;
    logic is_sfr;
    logic [7:0] byte_addr;
    logic [7:0] eff_mask;
    logic [7:0] eff_wdata;
    logic page_hit;
    logic occupied;
    logic shared;
    logic reserved;
    logic sfr_go;
    sfr_decode_pkg::read_src_t read_src;
    sfr_decode_pkg::read_src_t next_read_src;
    logic rd_bit;
    logic [2:0] rd_bit_idx;
    logic [7:0] raw_data;
    logic page_written;

    // Occupancy lookup for the active page
    sfr_page_map sfr_page_map_inst (
        .addr_in(byte_addr),
        .page_in(register_page_select),
        .occupied_out(occupied),
        .shared_out(shared)
    );

    // Address routing and bit translation
    always_comb begin
        is_sfr = acc_direct_in & acc_addr_in[7];
        if (acc_bit_in && acc_addr_in[7]) begin
            byte_addr = {acc_addr_in[7:3], 3'b000};
        end else if (acc_bit_in) begin
            byte_addr = sfr_decode_pkg::BIT_RAM_BASE | {4'h0, acc_addr_in[6:3]};
        end else begin
            byte_addr = acc_addr_in;
        end
        eff_mask = acc_bit_in ? (sfr_decode_pkg::ONE_BIT << acc_addr_in[2:0])
                              : sfr_decode_pkg::FULL_BYTE_MASK;
        eff_wdata = acc_bit_in ? {8{acc_wdata_in[0]}} : acc_wdata_in;
        // Page select is served here, so a write steers the very next access
        page_hit = is_sfr & ~acc_bit_in & (byte_addr == sfr_decode_pkg::PAGE_SEL_ADDR);
        reserved = is_sfr & ~occupied;
        sfr_go = acc_valid_in & is_sfr & occupied & ~page_hit;
    end

    // Page select register, new value seen by the next access
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            register_page_select <= sfr_decode_pkg::PAGE_RESET;
        end else if (acc_valid_in && acc_write_in && page_hit) begin
            register_page_select <= eff_wdata;
        end
    end

    assign page_out = register_page_select;

    // Strobes toward registers and RAM
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sfr_rd_out <= 1'b0;
            sfr_wr_out <= 1'b0;
            ram_rd_out <= 1'b0;
            ram_wr_out <= 1'b0;
            reserved_out <= 1'b0;
        end else begin
            sfr_rd_out <= sfr_go & ~acc_write_in;
            sfr_wr_out <= sfr_go & acc_write_in;
            ram_rd_out <= acc_valid_in & ~is_sfr & ~acc_write_in;
            ram_wr_out <= acc_valid_in & ~is_sfr & acc_write_in;
            reserved_out <= acc_valid_in & reserved;
        end
    end

    // Address, page and data of the access
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sfr_addr_out <= 8'h00;
            sfr_page_out <= sfr_decode_pkg::PAGE_RESET;
            sfr_shared_out <= 1'b0;
            ram_addr_out <= 8'h00;
            bit_mask_out <= 8'h00;
            wdata_out <= 8'h00;
        end else if (acc_valid_in) begin
            sfr_addr_out <= is_sfr ? byte_addr : 8'h00;
            sfr_page_out <= register_page_select;
            sfr_shared_out <= is_sfr & shared;
            ram_addr_out <= is_sfr ? 8'h00 : byte_addr;
            bit_mask_out <= eff_mask;
            wdata_out <= eff_wdata;
        end
    end

    // Source of the read answer
    always_comb begin
        next_read_src = sfr_decode_pkg::RD_NONE;
        if (acc_valid_in && !acc_write_in) begin
            if (!is_sfr) begin
                next_read_src = sfr_decode_pkg::RD_RAM;
            end else if (page_hit) begin
                next_read_src = sfr_decode_pkg::RD_PAGE;
            end else if (reserved) begin
                next_read_src = sfr_decode_pkg::RD_ZERO;
            end else begin
                next_read_src = sfr_decode_pkg::RD_SFR;
            end
        end
    end

    // Read tracking state
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            read_src <= sfr_decode_pkg::RD_NONE;
            rd_bit <= 1'b0;
            rd_bit_idx <= 3'h0;
        end else begin
            read_src <= next_read_src;
            rd_bit <= acc_bit_in;
            rd_bit_idx <= acc_addr_in[2:0];
        end
    end

    // Answer mux
    always_comb begin
        case (read_src)
            sfr_decode_pkg::RD_SFR: raw_data = sfr_rdata_in;
            sfr_decode_pkg::RD_RAM: raw_data = ram_rdata_in;
            sfr_decode_pkg::RD_PAGE: raw_data = register_page_select;
            default: raw_data = 8'h00;
        endcase
    end

    // Registered read answer, single bit for bit reads
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rd_valid_out <= 1'b0;
            rd_data_out <= 8'h00;
        end else begin
            rd_valid_out <= (read_src != sfr_decode_pkg::RD_NONE);
            rd_data_out <= rd_bit ? {7'h00, raw_data[rd_bit_idx]} : raw_data;
        end
    end

    // Helper: page select written since reset
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            page_written <= 1'b0;
        end else if (acc_valid_in && acc_write_in && page_hit) begin
            page_written <= 1'b1;
        end
    end

    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!rst_n_in);

    // Routing checks, one edge after the access is taken; the bit read lane check falls two edges after
    a_direct_to_sfr: assert property (sfr_go && !acc_write_in
        |=> sfr_rd_out && !ram_rd_out && sfr_addr_out == $past(byte_addr))
        else $error("direct read not routed to registers");
    a_strobe_exclusive: assert property (sfr_rd_out || sfr_wr_out
        |-> !ram_rd_out && !ram_wr_out)
        else $error("register and RAM strobed together");
    a_indirect_to_ram: assert property (acc_valid_in && !acc_direct_in
        |=> !sfr_rd_out && !sfr_wr_out && (ram_rd_out || ram_wr_out))
        else $error("indirect access hit registers");
    a_ram_addr_route: assert property (acc_valid_in && !is_sfr
        |=> ram_addr_out == $past(byte_addr) && sfr_addr_out == 8'h00)
        else $error("RAM access carried wrong addresses");
    a_bit_aligned: assert property ((sfr_rd_out || sfr_wr_out) && bit_mask_out != 8'hFF
        |-> sfr_addr_out[2:0] == 3'b000)
        else $error("bit access on non-bit address");
    a_bit_read_lane: assert property (rd_valid_out && $past(rd_bit)
        |-> rd_data_out[7:1] == 7'h00)
        else $error("bit read answer not in bit 0");
    a_byte_only_mask: assert property (sfr_wr_out
        |-> bit_mask_out == 8'hFF || $onehot(bit_mask_out))
        else $error("bad byte lane mask");
    a_byte_only_addr: assert property ((sfr_rd_out || sfr_wr_out) && sfr_addr_out[2:0] != 3'h0
        |-> bit_mask_out == sfr_decode_pkg::FULL_BYTE_MASK)
        else $error("bit access reached a byte-only register");
    a_reserved_quiet: assert property (acc_valid_in && reserved
        |=> reserved_out && !sfr_rd_out && !sfr_wr_out)
        else $error("reserved access strobed a register");
    // Paging checks
    a_page_follows: assert property (acc_valid_in && is_sfr
        |=> sfr_page_out == $past(register_page_select))
        else $error("wrong page driven");
    a_default_page: assert property (!page_written
        |-> register_page_select == sfr_decode_pkg::PAGE_RESET)
        else $error("page not zero before first write");
    a_pagef_set: assert property (acc_valid_in && is_sfr
        && register_page_select == sfr_decode_pkg::PAGE_F
        && sfr_decode_pkg::PAGEF_OCC_MASK[byte_addr[6:0]] |=> !reserved_out)
        else $error("page F register flagged reserved");
    a_shared_any_page: assert property (acc_valid_in && is_sfr && shared
        |=> !reserved_out && sfr_shared_out)
        else $error("shared register not decoded");
    a_page_read_back: assert property (acc_valid_in && !acc_write_in && page_hit
        |=> ##1 rd_valid_out && rd_data_out == $past(register_page_select))
        else $error("page select read mismatch");
    a_page_no_strobe: assert property (acc_valid_in && page_hit
        |=> !sfr_rd_out && !sfr_wr_out && !reserved_out)
        else $error("page select access strobed a register");
    a_page_next_use: assert property (acc_valid_in && acc_write_in && page_hit
        ##1 acc_valid_in && is_sfr |=> sfr_page_out == $past(eff_wdata, 2))
        else $error("page write not applied to next access");
endmodule : sfr_space_page_decoder

// [testbench/sfr_periph_model.sv]
`timescale 1ns/1ps
module sfr_periph_model (
    input wire logic sys_clk_in,        // Core clock
    input wire logic sfr_rd_in,         // Register read strobe
    input wire logic ram_rd_in,         // RAM read strobe
    input wire logic [7:0] sfr_addr_in, // Register address
    input wire logic [7:0] page_in,     // Page of the access
    input wire logic [7:0] ram_addr_in, // RAM address
    output logic [7:0] sfr_rdata_out,   // Register data
    output logic [7:0] ram_rdata_out    // RAM data
);
    logic [7:0] junk = 8'h00;
    // Filler that changes every cycle outside strobes
    always @(posedge sys_clk_in) junk <= junk + 8'h3B;
    // Answers are valid only in the strobe cycle
    assign sfr_rdata_out = sfr_rd_in ? (sfr_addr_in ^ page_in ^ 8'h5A) : junk;
    assign ram_rdata_out = ram_rd_in ? ~ram_addr_in : ~junk;
endmodule : sfr_periph_model

// [testbench/tb_sfr_space_page_decoder.sv]
`timescale 1ns/1ps
module tb_sfr_space_page_decoder;
    logic clk = 1'b0, rst_n = 1'b0, v = 1'b0, dir = 1'b0, bt = 1'b0, wr = 1'b0;
    logic [7:0] addr = 8'h00, wd = 8'h00, pg = 8'h00, srd, rrd;
    logic s_rd, s_wr, r_rd, r_wr, shd, res, rv;
    logic [7:0] s_addr, s_pg, r_addr, msk, wdo, rdo, pgo;
    logic [45:0] sq[$], cq[$];
    logic [7:0] rq[$];
    logic [7:0] pl[3] = '{8'h0F, 8'h03, 8'h00};
    int num_errors = 0, tests_run = 0;
    // Clock generation
    initial forever #12.5 clk = ~clk;
    sfr_space_page_decoder sfr_space_page_decoder_inst (.sys_clk_in(clk), .rst_n_in(rst_n),
        .acc_valid_in(v), .acc_direct_in(dir), .acc_bit_in(bt), .acc_write_in(wr),
        .acc_addr_in(addr), .acc_wdata_in(wd), .sfr_rdata_in(srd), .ram_rdata_in(rrd),
        .sfr_rd_out(s_rd), .sfr_wr_out(s_wr), .sfr_addr_out(s_addr), .sfr_page_out(s_pg),
        .sfr_shared_out(shd), .ram_rd_out(r_rd), .ram_wr_out(r_wr), .ram_addr_out(r_addr),
        .bit_mask_out(msk), .wdata_out(wdo), .reserved_out(res), .rd_valid_out(rv),
        .rd_data_out(rdo), .page_out(pgo));
    sfr_periph_model sfr_periph_model_inst (.sys_clk_in(clk), .sfr_rd_in(s_rd),
        .ram_rd_in(r_rd), .sfr_addr_in(s_addr), .page_in(s_pg), .ram_addr_in(r_addr),
        .sfr_rdata_out(srd), .ram_rdata_out(rrd));
    task automatic fail(input string m);
        num_errors++;
        $display("[ERR] %0t %s", $time, m);
    endtask : fail
    task automatic check_acc(input logic [45:0] e, c, a);
        tests_run++;
        if ((a & c) !== (e & c)) fail($sformatf("access %h want %h", a & c, e & c));
    endtask : check_acc
    task automatic check_rd(input logic [7:0] e, a);
        tests_run++;
        if (a !== e) fail($sformatf("data %h want %h", a, e));
    endtask : check_rd
    // Issue one access and note what must come back
    task automatic acc(input logic d, b, w, input logic [7:0] a, wdat);
        logic [7:0] by, ex;
        logic ram, sh, occ, ok, s;
        by = !b ? a : a[7] ? {a[7:3], 3'h0} : (8'h20 | a[6:3]);
        ram = !d || !by[7];
        sh = sfr_decode_pkg::SHARED_MASK[by[6:0]];
        occ = sh | (pg == sfr_decode_pkg::PAGE_ZERO && sfr_decode_pkg::PAGE0_OCC_MASK[by[6:0]])
            | (pg == sfr_decode_pkg::PAGE_F && sfr_decode_pkg::PAGEF_OCC_MASK[by[6:0]]);
        ok = ram || occ;
        s = !ram && occ;
        @(posedge clk) #1;
        {v, dir, bt, wr, addr, wd} = {1'b1, d, b, w, a, wdat};
        if (!ram && !b && a == sfr_decode_pkg::PAGE_SEL_ADDR) begin
            if (w) pg = wdat;
            else rq.push_back(pg);
        end else begin
            ex = ram ? ~by : occ ? (by ^ pg ^ 8'h5A) : 8'h00;
            if (!w) rq.push_back(b ? {7'h00, ex[a[2:0]]} : ex);
            sq.push_back({s && !w, s && w, ram && !w, ram && w, !ok, sh, ram ? 8'h00 : by,
                ram ? by : 8'h00, pg, b ? 8'h01 << a[2:0] : 8'hFF, b ? {8{wdat[0]}} : wdat});
            cq.push_back({5'h1F, !ram, {8{ok}}, 8'hFF, {8{s}}, {16{w && ok}}});
        end
    endtask : acc
    // Compare each answer with the oldest note
    always @(negedge clk) if (rst_n) begin
        if (s_rd | s_wr | r_rd | r_wr | res) begin
            if (sq.size() > 0) check_acc(sq.pop_front(), cq.pop_front(), {s_rd, s_wr, r_rd,
                r_wr, res, shd, s_addr, r_addr, s_pg, msk, wdo});
            else fail("unexpected access");
        end
        if (rv) begin
            if (rq.size() > 0) check_rd(rq.pop_front(), rdo);
            else fail("unexpected read answer");
        end
    end
    task automatic complete_run();
        if (sq.size() + rq.size() != 0) fail("answers missing");
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : complete_run
    // Watchdog against a hung run
    initial begin
        #(25 * 20000);
        fail("timeout");
        complete_run();
    end
    // Main sequence
    initial begin
        logic [31:0] r;
        logic b, d;
        void'($urandom(53581));
        repeat (16) @(posedge clk);
        #1 rst_n = 1'b1;
        check_rd(8'h00, pgo);
        acc(1'b1, 1'b0, 1'b0, 8'h81, 8'h00);
        acc(1'b0, 1'b0, 1'b1, 8'h81, 8'hC3);
        acc(1'b0, 1'b0, 1'b0, 8'hF0, 8'h00);
        acc(1'b1, 1'b0, 1'b1, 8'hB4, 8'h55);
        acc(1'b1, 1'b0, 1'b0, 8'hB4, 8'h00);
        acc(1'b1, 1'b1, 1'b1, 8'h83, 8'h01);
        acc(1'b1, 1'b1, 1'b0, 8'h13, 8'h00);
        acc(1'b1, 1'b0, 1'b1, 8'h83, 8'h5A);
        // Page F visit, foreign page, then back to page 0
        foreach (pl[k]) begin
            acc(1'b1, 1'b0, 1'b1, 8'hA7, pl[k]);
            acc(1'b1, 1'b0, 1'b0, 8'hA7, 8'h00);
            acc(1'b1, 1'b0, 1'b0, 8'hE2, 8'h00);
            repeat (40) begin
                r = $urandom;
                b = r[10] & r[11];
                d = r[8] | r[9] | b;
                acc(d, b, r[12], (b || !d) ? r[7:0] : (r[7:0] | 8'h80) ^ {7'h00,
                    r[6:0] == 7'h27}, r[23:16]);
            end
        end
        @(posedge clk) #1 v = 1'b0;
        repeat (4) @(posedge clk);
        check_rd(8'h00, pgo);
        complete_run();
    end
endmodule : tb_sfr_space_page_decoder
